// [logic/csms_sequencer.sv]
// colour sensor measurement sequencer with AXI4-Lite register access
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "csms_consts.svh"
module csms_sequencer #(
   parameter int CONV_UNIT_CYCLES =
      `CSMS_CONV_UNIT_US * 1000000 / `CSMS_CLK_PERIOD_PS,
   parameter int PAUSE_STEP_CYCLES =
      `CSMS_PAUSE_STEP_US * 1000000 / `CSMS_CLK_PERIOD_PS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sync_trigger_input,
   input wire csms_pkg::csms_word_t conv_data [4],
   output logic ready,
   output logic conv_active,
   output logic [3:0] gain_code,
   output logic [3:0] time_code
);
   import csms_pkg::*;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   function automatic csms_sel_t decode(input logic [7:0] a);
      csms_sel_t s;
      s = CSMS_SEL_NONE;
      case (a)
         `CSMS_OFF_OPSTATE: s = CSMS_SEL_OPSTATE;
         `CSMS_OFF_CFG1: s = CSMS_SEL_CFG1;
         `CSMS_OFF_CFG2: s = CSMS_SEL_CFG2;
         `CSMS_OFF_CFG3: s = CSMS_SEL_CFG3;
         `CSMS_OFF_PAUSE: s = CSMS_SEL_PAUSE;
         `CSMS_OFF_STATUS: s = CSMS_SEL_STATUS;
         default: begin
            if (a >= `CSMS_OFF_RES0 && a <= `CSMS_OFF_RES3 && a[1:0] == 2'b00) begin
               s = CSMS_SEL_RESULT;
            end
         end
      endcase
      return s;
   endfunction : decode

   // state gating of host access
   function automatic logic [1:0] access_resp(input csms_sel_t s, input logic meas);
      logic [1:0] r;
      r = RESP_OKAY;
      case (s)
         CSMS_SEL_NONE: r = RESP_DECERR;
         CSMS_SEL_CFG1, CSMS_SEL_CFG2, CSMS_SEL_CFG3: r = meas ? RESP_SLVERR : RESP_OKAY;
         CSMS_SEL_RESULT: r = meas ? RESP_OKAY : RESP_SLVERR;
         default: r = RESP_OKAY;
      endcase
      return r;
   endfunction : access_resp

   csms_mem_if mif ();

   csms_result_mem #(.WORDS(4)) u_mem (
      .clk(clk),
      .reset_n(reset_n),
      .mif(mif)
   );

   // register state
   logic [2:0] state_select_field_q;
   logic power_down_bit_q;
   logic start_stop_q;
   logic [7:0] first_config_reg_q;
   logic [7:0] second_config_reg_q;
   logic [7:0] third_config_reg_q;
   logic [7:0] pause_interval_q;
   logic ndata_q;
   logic ovwr_q;

   // sequencer state
   csms_seq_t seq_q;
   logic [31:0] cnt_q;
   logic ready_q;

   // trigger synchroniser
   logic trig_meta_q;
   logic trig_sync_q;
   logic trig_prev_q;
   logic trig_fall;

   // bus state
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rd_pend_q;
   csms_sel_t rd_sel_q;
   logic [1:0] rd_resp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic meas;
   csms_mode_t mode;
   logic wr_apply;
   csms_sel_t wr_sel;
   logic [1:0] wr_resp;
   logic wr_ok;
   logic op_write;
   logic to_config;
   logic store;
   logic abort;
   logic start_now;
   logic [31:0] conv_len;
   logic [31:0] pause_len;
   logic [3:0] tcode;

   assign meas = state_select_field_q == `CSMS_SEL_MEASURE;
   assign mode = csms_mode_t'(
      third_config_reg_q[`CSMS_CFG3_MODE_MSB:`CSMS_CFG3_MODE_LSB]);

   // write completes only with both address and data in hand
   assign wr_apply = aw_have_q && w_have_q && !bvalid_q;
   assign wr_sel = decode(aw_addr_q);
   assign wr_resp = access_resp(wr_sel, meas);
   assign wr_ok = wr_apply && wr_resp == RESP_OKAY && w_strb_q[0];
   assign op_write = wr_ok && wr_sel == CSMS_SEL_OPSTATE;
   assign to_config = op_write && meas &&
      w_data_q[`CSMS_SEL_MSB:0] == `CSMS_SEL_CONFIG;

   // conversion length doubles per time code, capped at the largest code
   assign tcode = first_config_reg_q[`CSMS_CFG1_TIME_MSB:0] > 4'(`CSMS_MAX_TIME_CODE) ?
      4'(`CSMS_MAX_TIME_CODE) : first_config_reg_q[`CSMS_CFG1_TIME_MSB:0];
   assign conv_len = 32'(CONV_UNIT_CYCLES) << tcode;
   assign pause_len = 32'(pause_interval_q) * 32'(PAUSE_STEP_CYCLES);

   // triggers are only looked at in idle, so pause edges are dropped
   assign start_now = seq_q == CSMS_ST_IDLE && meas && start_stop_q &&
      (mode == CSMS_MODE_CONTINUOUS_MODE || mode == CSMS_MODE_CMD || trig_fall);
   assign abort = seq_q == CSMS_ST_CONV && (!meas || !start_stop_q);
   assign store = seq_q == CSMS_ST_CONV && !abort && cnt_q == 32'h0000_0000;

   // trigger input
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_meta_q <= 1'b1;
         trig_sync_q <= 1'b1;
         trig_prev_q <= 1'b1;
      end else begin
         trig_meta_q <= sync_trigger_input;
         trig_sync_q <= trig_meta_q;
         trig_prev_q <= trig_sync_q;
      end
   end
   assign trig_fall = trig_prev_q && !trig_sync_q;

   // operational state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_select_field_q <= 3'(`CSMS_OPSTATE_RST & 8'h07);
         power_down_bit_q <= 1'b1;
         start_stop_q <= 1'b0;
      end else begin
         if (store && mode == CSMS_MODE_CMD) begin
            start_stop_q <= 1'b0;
         end
         // a host write in the same cycle overrides the self clear
         if (op_write) begin
            power_down_bit_q <= w_data_q[`CSMS_OPSTATE_PD_BIT];
            start_stop_q <= w_data_q[`CSMS_OPSTATE_SS_BIT];
            if (w_data_q[`CSMS_SEL_MSB:0] == `CSMS_SEL_CONFIG ||
               w_data_q[`CSMS_SEL_MSB:0] == `CSMS_SEL_MEASURE) begin
               state_select_field_q <= w_data_q[`CSMS_SEL_MSB:0];
            end
         end
      end
   end

   // configuration and pause registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         first_config_reg_q <= `CSMS_CFG1_RST;
         second_config_reg_q <= `CSMS_CFG2_RST;
         third_config_reg_q <= `CSMS_CFG3_RST;
         pause_interval_q <= `CSMS_PAUSE_RST;
      end else if (wr_ok) begin
         case (wr_sel)
            CSMS_SEL_CFG1: first_config_reg_q <= w_data_q[7:0];
            CSMS_SEL_CFG2: second_config_reg_q <= w_data_q[7:0];
            CSMS_SEL_CFG3: third_config_reg_q <= w_data_q[7:0];
            CSMS_SEL_PAUSE: pause_interval_q <= w_data_q[7:0];
            default: begin
            end
         endcase
      end
   end

   // conversion sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_q <= CSMS_ST_IDLE;
         cnt_q <= 32'h0000_0000;
         ready_q <= 1'b1;
      end else begin
         case (seq_q)
            CSMS_ST_IDLE: begin
               if (start_now) begin
                  seq_q <= CSMS_ST_CONV;
                  cnt_q <= conv_len - 32'h0000_0001;
                  ready_q <= 1'b0;
               end
            end
            CSMS_ST_CONV: begin
               if (abort) begin
                  seq_q <= CSMS_ST_IDLE;
                  ready_q <= 1'b1;
               end else if (store) begin
                  ready_q <= 1'b1;
                  if (mode == CSMS_MODE_CMD || pause_len == 32'h0000_0000) begin
                     seq_q <= CSMS_ST_IDLE;
                  end else begin
                     seq_q <= CSMS_ST_PAUSE;
                     cnt_q <= pause_len - 32'h0000_0001;
                  end
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            CSMS_ST_PAUSE: begin
               if (!meas || cnt_q == 32'h0000_0000) begin
                  seq_q <= CSMS_ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            default: begin
               seq_q <= CSMS_ST_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   // status flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ndata_q <= 1'b0;
         ovwr_q <= 1'b0;
      end else if (to_config) begin
         ndata_q <= 1'b0;
         ovwr_q <= 1'b0;
      end else if (store) begin
         ndata_q <= 1'b1;
         ovwr_q <= ovwr_q | ndata_q;
      end
   end

   // result store hookup
   assign mif.store = store;
   assign mif.clear = to_config;
   assign mif.wr_words = conv_data;
   assign mif.rd_en = s_axi_arvalid && s_axi_arready;
   assign mif.rd_idx = csms_ridx_t'((s_axi_araddr - `CSMS_OFF_RES0) >> 2);

   // register bus write channel
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_apply) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_resp;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // register bus read channel
   // one cycle in the store's read register, one in the data register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend_q <= 1'b0;
         rd_sel_q <= CSMS_SEL_NONE;
         rd_resp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            rd_pend_q <= 1'b1;
            rd_sel_q <= decode(s_axi_araddr);
            rd_resp_q <= access_resp(decode(s_axi_araddr), meas);
         end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= rd_resp_q;
            rdata_q <= 32'h0000_0000;
            if (rd_resp_q == RESP_OKAY) begin
               case (rd_sel_q)
                  CSMS_SEL_OPSTATE: rdata_q[7:0] <= {start_stop_q, power_down_bit_q, 3'b000,
                     state_select_field_q};
                  CSMS_SEL_CFG1: rdata_q[7:0] <= first_config_reg_q;
                  CSMS_SEL_CFG2: rdata_q[7:0] <= second_config_reg_q;
                  CSMS_SEL_CFG3: rdata_q[7:0] <= third_config_reg_q;
                  CSMS_SEL_PAUSE: rdata_q[7:0] <= pause_interval_q;
                  CSMS_SEL_STATUS: begin
                     rdata_q[`CSMS_STAT_NDATA_BIT] <= ndata_q;
                     rdata_q[`CSMS_STAT_OVWR_BIT] <= ovwr_q;
                     rdata_q[`CSMS_STAT_BUSY_BIT] <= seq_q == CSMS_ST_CONV;
                     rdata_q[`CSMS_STAT_PAUSE_BIT] <= seq_q == CSMS_ST_PAUSE;
                     rdata_q[`CSMS_STAT_PD_BIT] <= power_down_bit_q;
                  end
                  CSMS_SEL_RESULT: rdata_q[15:0] <= mif.rd_data;
                  default: rdata_q <= 32'h0000_0000;
               endcase
            end
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_arready = !rd_pend_q && !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // outputs to the converter
   assign ready = ready_q;
   assign conv_active = seq_q == CSMS_ST_CONV;
   assign gain_code = first_config_reg_q[7:4];
   assign time_code = tcode;
endmodule : csms_sequencer

// [logic/csms_consts.svh]
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef CSMS_CONSTS_SVH
`define CSMS_CONSTS_SVH

`define CSMS_OFF_OPSTATE 8'h00
`define CSMS_OFF_CFG1 8'h04
`define CSMS_OFF_CFG2 8'h08
`define CSMS_OFF_CFG3 8'h0C
`define CSMS_OFF_PAUSE 8'h10
`define CSMS_OFF_STATUS 8'h14
`define CSMS_OFF_RES0 8'h18
`define CSMS_OFF_RES3 8'h24

`define CSMS_OPSTATE_SS_BIT 7
`define CSMS_OPSTATE_PD_BIT 6
`define CSMS_SEL_MSB 2
`define CSMS_SEL_NOP 3'h0
`define CSMS_SEL_CONFIG 3'h2
`define CSMS_SEL_MEASURE 3'h3
`define CSMS_CFG1_TIME_MSB 3
`define CSMS_CFG3_MODE_MSB 7
`define CSMS_CFG3_MODE_LSB 6

`define CSMS_OPSTATE_RST 8'h42
`define CSMS_CFG1_RST 8'hA6
`define CSMS_CFG2_RST 8'h40
`define CSMS_CFG3_RST 8'h40
`define CSMS_PAUSE_RST 8'h52

`define CSMS_STAT_NDATA_BIT 0
`define CSMS_STAT_OVWR_BIT 1
`define CSMS_STAT_BUSY_BIT 2
`define CSMS_STAT_PAUSE_BIT 3
`define CSMS_STAT_PD_BIT 4

`define CSMS_CLK_PERIOD_PS 4000
`define CSMS_PAUSE_STEP_US 8
`define CSMS_CONV_UNIT_US 1024
`define CSMS_MAX_TIME_CODE 11

`endif

// [logic/csms_pkg.sv]
// types shared by the colour sensor measurement sequencer
package csms_pkg;
   typedef enum logic [1:0] {
      CSMS_MODE_CONTINUOUS_MODE,
      CSMS_MODE_CMD,
      CSMS_MODE_TRIGGER_START_MODE,
      CSMS_MODE_TRIGGER_START_END_MODE
   } csms_mode_t;

   typedef enum logic [1:0] {
      CSMS_ST_IDLE,
      CSMS_ST_CONV,
      CSMS_ST_PAUSE
   } csms_seq_t;

   typedef enum logic [3:0] {
      CSMS_SEL_NONE,
      CSMS_SEL_OPSTATE,
      CSMS_SEL_CFG1,
      CSMS_SEL_CFG2,
      CSMS_SEL_CFG3,
      CSMS_SEL_PAUSE,
      CSMS_SEL_STATUS,
      CSMS_SEL_RESULT
   } csms_sel_t;

   typedef logic [15:0] csms_word_t;
   typedef logic [1:0] csms_ridx_t;
endpackage : csms_pkg

// [logic/csms_mem_if.sv]
// carrier between the sequencer and its result store
`timescale 1ns/1ps
interface csms_mem_if;
   import csms_pkg::*;
   logic store;
   logic clear;
   csms_word_t wr_words [4];
   logic rd_en;
   csms_ridx_t rd_idx;
   csms_word_t rd_data;

   modport ctrl (output store, output clear, output wr_words, output rd_en, output rd_idx,
      input rd_data);
   modport mem (input store, input clear, input wr_words, input rd_en, input rd_idx,
      output rd_data);
endinterface : csms_mem_if

// [logic/csms_result_mem.sv]
// result store: three light channels and the temperature word
`timescale 1ns/1ps
module csms_result_mem #(
   parameter int WORDS = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   csms_mem_if.mem mif
);
   import csms_pkg::*;

   csms_word_t word_q [WORDS];
   csms_word_t rd_q;

   // clear beats store so a config switch never leaves a stale result
   genvar g;
   generate
      for (g = 0; g < WORDS; g++) begin : g_word
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               word_q[g] <= 16'h0000;
            end else if (mif.clear) begin
               word_q[g] <= 16'h0000;
            end else if (mif.store) begin
               word_q[g] <= mif.wr_words[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 16'h0000;
      end else if (mif.rd_en) begin
         rd_q <= word_q[mif.rd_idx];
      end
   end

   assign mif.rd_data = rd_q;
endmodule : csms_result_mem

// [verif/csms_sequencer_checker.sv]
// port-level assertions for the measurement sequencer
`timescale 1ns/1ps
module csms_sequencer_checker #(
   parameter int CONV_UNIT_CYCLES = 16,
   parameter int PAUSE_STEP_CYCLES = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ready,
   input wire logic conv_active,
   input wire logic [3:0] time_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] low_cnt_q;
   // counts how long ready has been low, so the length can be bounded
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_q <= 16'h0000;
      end else begin
         low_cnt_q <= ready ? 16'h0000 : low_cnt_q + 16'h0001;
      end
   end
   a_ready_low_conv: assert property (conv_active |-> !ready)
      else $error("ready high during conversion");
   a_ready_rise_end: assert property ($rose(ready) |->
      $past(conv_active) || $past(conv_active, 2))
      else $error("ready rose without a conversion");
   a_conv_length: assert property (low_cnt_q <= (CONV_UNIT_CYCLES << time_code) + 1)
      else $error("conversion longer than programmed");
   a_time_capped: assert property (time_code <= 4'hB)
      else $error("time code above limit");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("no write response");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
      else $error("no read response");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response changed");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   c_conv: cover property ($rose(conv_active));
   c_done: cover property ($rose(ready));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : csms_sequencer_checker

bind csms_sequencer csms_sequencer_checker #(.CONV_UNIT_CYCLES(CONV_UNIT_CYCLES),
   .PAUSE_STEP_CYCLES(PAUSE_STEP_CYCLES)) csms_sequencer_checker_inst (.clk, .reset_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .ready, .conv_active, .time_code);

// [verif/csms_front_model.sv]
// far side model: sensor front end words and the trigger pin
`timescale 1ns/1ps
module csms_front_model (
   input wire logic link_clk,
   input wire logic fire,
   input wire csms_pkg::csms_word_t words [4],
   output csms_pkg::csms_word_t conv_data [4],
   output logic sync_trigger_input
);
   import csms_pkg::*;
   logic seen_q = 1'b0;
   logic trig_q = 1'b1;
   assign conv_data = words;
   assign sync_trigger_input = trig_q;
   // one low link period, far above the three-clock minimum pulse width
   always @(posedge link_clk) begin
      if (fire != seen_q) begin
         seen_q <= fire;
         trig_q <= 1'b0;
      end else begin
         trig_q <= 1'b1;
      end
   end
endmodule : csms_front_model

// [verif/test_color_sensor_measure_sequencer.sv]
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module test_color_sensor_measure_sequencer;
   import csms_pkg::*;
   localparam int CU = 16;
   localparam int PS = 4;
   localparam int LIMIT = 20000;
   localparam logic [1:0] OK = 2'h0;
   localparam logic [1:0] SLV = 2'h2;
   localparam logic [1:0] DEC = 2'h3;
   typedef struct {logic [1:0] resp; logic [31:0] data; logic any;} csms_note_t;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic sync_trigger_input;
   logic fire = 1'b0;
   csms_word_t words [4] = '{default: 16'h0000};
   csms_word_t old_w [4];
   csms_word_t conv_data [4];
   logic ready;
   logic conv_active;
   logic [3:0] gain_code;
   logic [3:0] time_code;
   logic [31:0] rst_v [6] = '{32'h42, 32'hA6, 32'h40, 32'h40, 32'h52, 32'h10};
   csms_note_t note_q [$];
   csms_note_t note;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;

   always #2 clk = ~clk;
   // link clock offset so its edges never line up with the core clock
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   csms_sequencer #(.CONV_UNIT_CYCLES(CU), .PAUSE_STEP_CYCLES(PS)) csms_sequencer_inst (.clk,
      .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sync_trigger_input, .conv_data, .ready, .conv_active, .gain_code, .time_code);
   csms_front_model csms_front_model_inst (.link_clk, .fire, .words, .conv_data,
      .sync_trigger_input);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      note_q.push_back('{r, 32'h0, 1'b1});
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      note_q.push_back('{r, d, r == DEC});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   // waits up to 300 cycles for a conversion, then counts its low cycles
   task automatic measure(output int len);
      int w;
      len = 0;
      w = 0;
      while (ready === 1'b1 && w < 300) begin
         @(posedge clk);
         w++;
      end
      while (ready === 1'b0) begin
         @(posedge clk);
         len++;
      end
   endtask : measure

   task automatic go(input logic [7:0] d, output int len);
      fork
         wr(8'h00, d, OK);
         measure(len);
      join
   endtask : go

   task automatic load();
      foreach (words[i]) words[i] <= 16'($urandom);
      @(posedge clk);
   endtask : load

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         results();
      end
      if (reset_n && s_axi_bvalid && s_axi_bready) begin
         note = note_q.pop_front();
         check({30'h0, s_axi_bresp}, {30'h0, note.resp});
      end
      if (reset_n && s_axi_rvalid && s_axi_rready) begin
         note = note_q.pop_front();
         check({30'h0, s_axi_rresp}, {30'h0, note.resp});
         if (!note.any) check(s_axi_rdata, note.data);
      end
   end

   initial begin
      void'($urandom(14323));
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check({31'h0, ready}, 32'h1);
      foreach (rst_v[i]) rd(8'(4 * i), rst_v[i], OK);
      rd(8'h18, 32'h0, SLV);
      rd(8'h30, 32'h0, DEC);
      wr(8'h14, 8'hFF, OK);
      rd(8'h14, 32'h10, OK);
      wr(8'h00, 8'h02, OK);
      rd(8'h00, 32'h02, OK);
      wr(8'h04, 8'h5F, OK);
      check({24'h0, gain_code, time_code}, 32'h5B);
      wr(8'h04, 8'h01, OK);
      wr(8'h10, 8'h08, OK);
      load();
      go(8'h83, n);
      check(32'(n), 32'(CU * 2));
      rd(8'h00, 32'h03, OK);
      for (int i = 0; i < 4; i++) rd(8'(8'h18 + 4 * i), {16'h0, words[i]}, OK);
      rd(8'h14, 32'h01, OK);
      rd(8'h04, 32'h0, SLV);
      wr(8'h04, 8'h0F, SLV);
      check({28'h0, time_code}, 32'h1);
      load();
      go(8'h80, n);
      check(32'(n), 32'(CU * 2));
      rd(8'h14, 32'h03, OK);
      wr(8'h00, 8'h02, OK);
      rd(8'h14, 32'h00, OK);
      rd(8'h18, 32'h0, SLV);
      wr(8'h00, 8'h03, OK);
      wr(8'h00, 8'h00, OK);
      rd(8'h00, 32'h03, OK);
      rd(8'h1C, 32'h0, OK);
      wr(8'h00, 8'h02, OK);
      wr(8'h0C, 8'h80, OK);
      wr(8'h00, 8'h03, OK);
      load();
      fire <= ~fire;
      measure(n);
      check(32'(n), 32'h0);
      wr(8'h00, 8'h80, OK);
      fire <= ~fire;
      measure(n);
      check(32'(n), 32'(CU * 2));
      fire <= ~fire;
      measure(n);
      check(32'(n), 32'h0);
      rd(8'h18, {16'h0, words[0]}, OK);
      fire <= ~fire;
      measure(n);
      check(32'(n), 32'(CU * 2));
      wr(8'h00, 8'h02, OK);
      wr(8'h0C, 8'h00, OK);
      go(8'hC3, n);
      check(32'(n), 32'(CU * 2));
      measure(n);
      check(32'(n), 32'(CU * 2));
      old_w = words;
      load();
      while (conv_active !== 1'b1) @(posedge clk);
      wr(8'h00, 8'h03, OK);
      check({31'h0, ready}, 32'h1);
      measure(n);
      check(32'(n), 32'h0);
      rd(8'h18, {16'h0, old_w[0]}, OK);
      results();
   end
endmodule : test_color_sensor_measure_sequencer
